// ---- src/ptf_timers.sv ----
// Edge-triggered interval relay, symmetrical and asynchronous pulse generators and a
// random on/off delay, all stepped by one shared time-base tick.
// Assumes all inputs are synchronous to MCLK and times are given in ticks.
//
// How it works
// - A trigger rising edge starts low_time; then output is high for high_time.
// - A new trigger during the sequence clears elapsed_time and restarts it.
// - The relay reset input forces the output low and clears elapsed_time.
// - Each trigger gives repeat_total low/high cycles, repeat_total from one to nine.
// - Legacy variant: only high_time, used as an output off-delay; no reset input.
// - With retentivity on, relay timing state and output survive a restart.
// - Any timing value may come from another block's value, chosen by number.
// - Symmetrical generator: high then low for half_period each while enabled.
// - Asynchronous generator alternates high for high_time and low for low_time.
// - Polarity flip inverts the asynchronous output only while it is enabled.
// - Enable rise starts a random on-delay up to high_time; sets output if still on.
// - Enable falling during the on-delay cancels it; output unchanged.
// - Enable fall starts a random off-delay up to low_time; clears output if still off.
// - Enable returning high during the off-delay cancels it; output stays set.
`include "ptf_defines.svh"

module ptf_timers #(
    parameter int unsigned TICK_CYCLES = `PTF_TICK_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic RESTART,
    input wire ptf_pkg::ptf_time_t SRC_VAL_1,
    input wire ptf_pkg::ptf_time_t SRC_VAL_2,
    input wire ptf_pkg::ptf_time_t SRC_VAL_3,
    input wire ptf_pkg::ptf_time_t SRC_VAL_4,
    input wire logic ETR_TRG,
    input wire logic ETR_RST,
    input wire logic ETR_LEGACY,
    input wire logic ETR_RETAIN,
    input wire logic [`PTF_REP_W-1:0] ETR_REPEAT,
    input wire ptf_pkg::ptf_time_t ETR_HIGH_TIME,
    input wire ptf_pkg::ptf_time_t ETR_LOW_TIME,
    input wire logic [`PTF_SEL_W-1:0] ETR_HIGH_SEL,
    input wire logic [`PTF_SEL_W-1:0] ETR_LOW_SEL,
    input wire logic SYM_EN,
    input wire ptf_pkg::ptf_time_t SYM_HALF_PERIOD,
    input wire logic [`PTF_SEL_W-1:0] SYM_HALF_SEL,
    input wire logic ASY_EN,
    input wire logic ASY_POLARITY_FLIP,
    input wire ptf_pkg::ptf_time_t ASY_HIGH_TIME,
    input wire ptf_pkg::ptf_time_t ASY_LOW_TIME,
    input wire logic [`PTF_SEL_W-1:0] ASY_HIGH_SEL,
    input wire logic [`PTF_SEL_W-1:0] ASY_LOW_SEL,
    input wire logic RND_EN,
    input wire ptf_pkg::ptf_time_t RND_HIGH_TIME,
    input wire ptf_pkg::ptf_time_t RND_LOW_TIME,
    input wire logic [`PTF_SEL_W-1:0] RND_HIGH_SEL,
    input wire logic [`PTF_SEL_W-1:0] RND_LOW_SEL,
    output logic ETR_Q,
    output ptf_pkg::ptf_time_t ETR_ELAPSED,
    output logic SYM_Q,
    output logic ASY_Q,
    output logic RND_Q
);
    import ptf_pkg::*;

    // Parameter sources gathered into arrays so one loop resolves them all.
    ptf_time_t src_v [`PTF_NSRC];
    ptf_time_t const_v [`PTF_NPARAM];
    logic [`PTF_SEL_W-1:0] sel_v [`PTF_NPARAM];
    ptf_time_t tv [`PTF_NPARAM];
    assign src_v = '{SRC_VAL_1, SRC_VAL_2, SRC_VAL_3, SRC_VAL_4};
    assign const_v = '{ETR_HIGH_TIME, ETR_LOW_TIME, SYM_HALF_PERIOD, ASY_HIGH_TIME,
                       ASY_LOW_TIME, RND_HIGH_TIME, RND_LOW_TIME};
    assign sel_v = '{ETR_HIGH_SEL, ETR_LOW_SEL, SYM_HALF_SEL, ASY_HIGH_SEL,
                     ASY_LOW_SEL, RND_HIGH_SEL, RND_LOW_SEL};

    // Selector zero takes the constant; one to four take that block's current value.
    for (genvar i = 0; i < `PTF_NPARAM; i++) begin : g_param
        logic [`PTF_SEL_W-1:0] idx;
        assign idx = sel_v[i] - `PTF_SEL_W'(1);
        assign tv[i] = (sel_v[i] != '0 && sel_v[i] <= `PTF_SEL_W'(`PTF_NSRC)) ?
                       src_v[idx[1:0]] : const_v[i];
    end

    ptf_time_t etr_th, etr_tl, sym_t, asy_th, asy_tl, rnd_th, rnd_tl;
    assign etr_th = tv[0];
    assign etr_tl = tv[1];
    assign sym_t = tv[2];
    assign asy_th = tv[3];
    assign asy_tl = tv[4];
    assign rnd_th = tv[5];
    assign rnd_tl = tv[6];

    // Time-base divider: one-cycle tick every TICK_CYCLES clocks.
    logic [`PTF_DIV_W-1:0] div_q;
    logic tick;
    assign tick = (div_q == `PTF_DIV_W'(TICK_CYCLES - 1));
    always_ff @(posedge MCLK) begin
        div_q <= (RST || tick) ? '0 : div_q + `PTF_DIV_W'(1);
    end

    // Free-running Galois LFSR feeding both random delays.
    logic [15:0] lfsr_q;
    always_ff @(posedge MCLK) begin
        if (RST) lfsr_q <= `PTF_LFSR_SEED;
        else lfsr_q <= (lfsr_q >> 1) ^ (lfsr_q[0] ? `PTF_LFSR_TAPS : 16'h0000);
    end

    // Input history for edge detection.
    logic etr_trg_q, sym_en_q, rnd_en_q;
    always_ff @(posedge MCLK) begin
        etr_trg_q <= RST ? 1'b0 : ETR_TRG;
        sym_en_q <= RST ? 1'b0 : SYM_EN;
        rnd_en_q <= RST ? 1'b0 : RND_EN;
    end

    // ---------------- Edge-triggered interval relay ----------------
    ptf_etr_state_t etr_st_q, etr_st_d;
    ptf_time_t etr_el_q, etr_el_d;
    logic [`PTF_REP_W-1:0] etr_cnt_q, etr_cnt_d, etr_rep;
    logic etr_q_q, etr_q_d, etr_rise;
    logic [`PTF_TIME_W:0] etr_el_inc;
    assign etr_rise = ETR_TRG && !etr_trg_q;
    assign etr_el_inc = {1'b0, etr_el_q} + 17'h00001;
    assign etr_rep = (ETR_REPEAT < `PTF_REP_MIN) ? `PTF_REP_MIN :
                     (ETR_REPEAT > `PTF_REP_MAX) ? `PTF_REP_MAX : ETR_REPEAT;

    // Next state of the relay: restart, reset, trigger, then tick-driven timing.
    always_comb begin
        etr_st_d = etr_st_q;
        etr_el_d = etr_el_q;
        etr_cnt_d = etr_cnt_q;
        etr_q_d = etr_q_q;
        if (RESTART) begin
            if (!ETR_RETAIN) begin
                etr_st_d = ETR_IDLE;
                etr_el_d = '0;
                etr_cnt_d = '0;
                etr_q_d = 1'b0;
            end
        end else if (ETR_RST && !ETR_LEGACY) begin
            etr_st_d = ETR_IDLE;
            etr_el_d = '0;
            etr_cnt_d = '0;
            etr_q_d = 1'b0;
        end else if (etr_rise) begin
            etr_el_d = '0;
            etr_cnt_d = '0;
            etr_st_d = ETR_LEGACY ? ETR_HIGH : ETR_LOW;
            etr_q_d = ETR_LEGACY;
        end else if (tick) begin
            case (etr_st_q)
                ETR_LOW: begin
                    if (etr_el_inc >= {1'b0, etr_tl}) begin
                        etr_st_d = ETR_HIGH;
                        etr_q_d = 1'b1;
                        etr_el_d = '0;
                    end else begin
                        etr_el_d = etr_el_inc[`PTF_TIME_W-1:0];
                    end
                end
                ETR_HIGH: begin
                    if (etr_el_inc >= {1'b0, etr_th}) begin
                        etr_q_d = 1'b0;
                        etr_el_d = '0;
                        if (ETR_LEGACY || etr_cnt_q + `PTF_REP_W'(1) >= etr_rep) begin
                            etr_st_d = ETR_IDLE;
                            etr_cnt_d = '0;
                        end else begin
                            etr_st_d = ETR_LOW;
                            etr_cnt_d = etr_cnt_q + `PTF_REP_W'(1);
                        end
                    end else begin
                        etr_el_d = etr_el_inc[`PTF_TIME_W-1:0];
                    end
                end
                default: etr_st_d = ETR_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        etr_st_q <= RST ? ETR_IDLE : etr_st_d;
        etr_el_q <= RST ? '0 : etr_el_d;
        etr_cnt_q <= RST ? '0 : etr_cnt_d;
        etr_q_q <= RST ? 1'b0 : etr_q_d;
    end

    // ---------------- Symmetrical clock generator ----------------
    ptf_time_t sym_el_q, sym_el_d;
    logic sym_q_q, sym_q_d;

    // Starts high on enable, toggles every half_period ticks, low when disabled.
    always_comb begin
        sym_el_d = sym_el_q;
        sym_q_d = sym_q_q;
        if (!SYM_EN) begin
            sym_el_d = '0;
            sym_q_d = 1'b0;
        end else if (!sym_en_q) begin
            sym_el_d = '0;
            sym_q_d = 1'b1;
        end else if (tick) begin
            if ({1'b0, sym_el_q} + 17'h00001 >= {1'b0, sym_t}) begin
                sym_el_d = '0;
                sym_q_d = !sym_q_q;
            end else begin
                sym_el_d = sym_el_q + `PTF_TIME_W'(1);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        sym_el_q <= RST ? '0 : sym_el_d;
        sym_q_q <= RST ? 1'b0 : sym_q_d;
    end

    // ---------------- Asynchronous pulse generator ----------------
    ptf_time_t asy_el_q, asy_el_d, asy_lim;
    logic asy_ph_q, asy_ph_d, asy_q_q, asy_q_d;
    assign asy_lim = asy_ph_q ? asy_th : asy_tl;
    assign asy_q_d = ASY_EN && (asy_ph_d ^ ASY_POLARITY_FLIP);

    // Phase high lasts high_time, phase low lasts low_time; idle parks in high phase.
    always_comb begin
        asy_el_d = asy_el_q;
        asy_ph_d = asy_ph_q;
        if (!ASY_EN) begin
            asy_el_d = '0;
            asy_ph_d = 1'b1;
        end else if (tick) begin
            if ({1'b0, asy_el_q} + 17'h00001 >= {1'b0, asy_lim}) begin
                asy_el_d = '0;
                asy_ph_d = !asy_ph_q;
            end else begin
                asy_el_d = asy_el_q + `PTF_TIME_W'(1);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        asy_el_q <= RST ? '0 : asy_el_d;
        asy_ph_q <= RST ? 1'b1 : asy_ph_d;
        asy_q_q <= RST ? 1'b0 : asy_q_d;
    end

    // ---------------- Random on/off delay ----------------
    ptf_rnd_state_t rnd_st_q, rnd_st_d;
    ptf_time_t rnd_el_q, rnd_el_d, rnd_dly_q, rnd_dly_d, rnd_on_dly, rnd_off_dly;
    logic rnd_q_q, rnd_q_d, rnd_rise, rnd_fall;
    logic [32:0] rnd_on_prod, rnd_off_prod;
    assign rnd_rise = RND_EN && !rnd_en_q;
    assign rnd_fall = !RND_EN && rnd_en_q;
    // Scaling keeps each delay within zero to the configured maximum.
    assign rnd_on_prod = lfsr_q * ({1'b0, rnd_th} + 17'h00001);
    assign rnd_off_prod = lfsr_q * ({1'b0, rnd_tl} + 17'h00001);
    assign rnd_on_dly = rnd_on_prod[31:16];
    assign rnd_off_dly = rnd_off_prod[31:16];

    // Edges load a fresh delay, which also cancels whichever delay was running.
    always_comb begin
        rnd_st_d = rnd_st_q;
        rnd_el_d = rnd_el_q;
        rnd_dly_d = rnd_dly_q;
        rnd_q_d = rnd_q_q;
        if (rnd_rise) begin
            rnd_st_d = RND_ON;
            rnd_el_d = '0;
            rnd_dly_d = rnd_on_dly;
        end else if (rnd_fall) begin
            rnd_st_d = RND_OFF;
            rnd_el_d = '0;
            rnd_dly_d = rnd_off_dly;
        end else begin
            case (rnd_st_q)
                RND_ON: begin
                    if (rnd_el_q >= rnd_dly_q) begin
                        rnd_q_d = 1'b1;
                        rnd_st_d = RND_IDLE;
                    end else if (tick) begin
                        rnd_el_d = rnd_el_q + `PTF_TIME_W'(1);
                    end
                end
                RND_OFF: begin
                    if (rnd_el_q >= rnd_dly_q) begin
                        rnd_q_d = 1'b0;
                        rnd_st_d = RND_IDLE;
                    end else if (tick) begin
                        rnd_el_d = rnd_el_q + `PTF_TIME_W'(1);
                    end
                end
                default: rnd_st_d = RND_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        rnd_st_q <= RST ? RND_IDLE : rnd_st_d;
        rnd_el_q <= RST ? '0 : rnd_el_d;
        rnd_dly_q <= RST ? '0 : rnd_dly_d;
        rnd_q_q <= RST ? 1'b0 : rnd_q_d;
    end

    // Outputs come straight from the state flip-flops.
    assign ETR_Q = etr_q_q;
    assign ETR_ELAPSED = etr_el_q;
    assign SYM_Q = sym_q_q;
    assign ASY_Q = asy_q_q;
    assign RND_Q = rnd_q_q;

    // Checks on the timing behaviour, sampled on the system clock.
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_etr_reset_clears: assert property (
        !RESTART && ETR_RST && !ETR_LEGACY |=> !ETR_Q && ETR_ELAPSED == '0)
        else $error("Relay reset did not clear output and elapsed time.");
    a_etr_retrigger: assert property (
        !RESTART && !ETR_RST && !ETR_LEGACY && ETR_TRG && !etr_trg_q
        |=> etr_st_q == ETR_LOW && ETR_ELAPSED == '0 && !ETR_Q)
        else $error("Trigger did not restart the low interval.");
    a_etr_high_out: assert property (
        etr_st_q == ETR_HIGH |-> ETR_Q)
        else $error("Relay output low during the high interval.");
    a_etr_count_max: assert property (
        etr_cnt_q < `PTF_REP_MAX)
        else $error("Relay pulse count left its range.");
    a_legacy_pulse: assert property (
        !RESTART && ETR_LEGACY && ETR_TRG && !etr_trg_q |=> ETR_Q && etr_st_q == ETR_HIGH)
        else $error("Legacy trigger did not set the output.");
    a_retain_keeps: assert property (
        RESTART && ETR_RETAIN |=> etr_st_q == $past(etr_st_q) && ETR_Q == $past(ETR_Q))
        else $error("Retained relay state changed on restart.");
    a_sym_disabled: assert property (
        !SYM_EN |=> !SYM_Q)
        else $error("Symmetrical output high while disabled.");
    a_sym_starts_high: assert property (
        SYM_EN && !sym_en_q |=> SYM_Q ##1 (SYM_Q || !$past(SYM_EN) || $past(tick)))
        else $error("Symmetrical generator did not start high.");
    a_asy_disabled: assert property (
        !ASY_EN |=> !ASY_Q)
        else $error("Asynchronous output set while disabled.");
    a_rnd_on_cancel: assert property (
        rnd_st_q == RND_ON && !RND_EN |=> rnd_st_q != RND_ON && RND_Q == $past(RND_Q))
        else $error("On-delay not cancelled by enable falling.");
    a_rnd_set_needs_en: assert property (
        $rose(RND_Q) |-> $past(RND_EN))
        else $error("Random output set without enable.");
    a_rnd_clear_off: assert property (
        $fell(RND_Q) && !$past(RST) |-> !$past(RND_EN))
        else $error("Random output cleared while enabled.");
    a_rnd_off_cancel: assert property (
        rnd_st_q == RND_OFF && RND_EN |=> rnd_st_q == RND_ON && RND_Q == $past(RND_Q))
        else $error("Off-delay not cancelled by enable returning.");
    a_tick_single: assert property (
        tick |=> !tick)
        else $error("Time-base tick lasted more than one cycle.");

    c_etr_burst: cover property (etr_st_q == ETR_HIGH && etr_cnt_q == 4'h2);
    c_asy_inverted: cover property (ASY_EN && ASY_POLARITY_FLIP && ASY_Q);
    c_rnd_set: cover property ($rose(RND_Q));
    c_rnd_cancel: cover property (rnd_st_q == RND_OFF && RND_EN);

endmodule

// ---- src/ptf_defines.svh ----
// Constants for the pulse and random timer block: widths, time base and limits.
// Assumes it is included by the package and the timer module by its bare name.
`ifndef PTF_DEFINES_SVH
`define PTF_DEFINES_SVH

// Width of every timing value and elapsed-time counter, in time-base ticks.
`define PTF_TIME_W 16
// System clock rate and the time-base tick period derived from it.
`define PTF_CLK_HZ 200000000
`define PTF_TICK_MS 10
`define PTF_TICK_CYCLES ((`PTF_CLK_HZ / 1000) * `PTF_TICK_MS)
`define PTF_DIV_W 32
// Number of timing parameters and of external value sources.
`define PTF_NPARAM 7
`define PTF_NSRC 4
`define PTF_SEL_W 3
// Pulse repeat range of the edge-triggered relay.
`define PTF_REP_W 4
`define PTF_REP_MIN 4'h1
`define PTF_REP_MAX 4'h9
// Pseudo-random source seed and feedback taps.
`define PTF_LFSR_SEED 16'hace1
`define PTF_LFSR_TAPS 16'hb400

`endif

// ---- src/ptf_pkg.sv ----
// Types shared by the pulse and random timer block.
// Assumes ptf_defines.svh is on the include path.
`include "ptf_defines.svh"

package ptf_pkg;

    typedef logic [`PTF_TIME_W-1:0] ptf_time_t;

    typedef enum logic [1:0] {
        ETR_IDLE = 2'b00,
        ETR_LOW  = 2'b01,
        ETR_HIGH = 2'b10
    } ptf_etr_state_t;

    typedef enum logic [1:0] {
        RND_IDLE = 2'b00,
        RND_ON   = 2'b01,
        RND_OFF  = 2'b10
    } ptf_rnd_state_t;

endpackage

// ---- testbench/ptf_src_model.sv ----
// Model of the neighbouring program blocks whose current values feed the timer selectors.
// Assumes MCLK and RST are shared with the timer block; values are in time-base ticks.
module ptf_src_model #(
    parameter logic [15:0] V1 = 16'h0002,
    parameter logic [15:0] V2 = 16'h0005,
    parameter logic [15:0] V3 = 16'h0001,
    parameter logic [15:0] V4 = 16'h0003
) (
    input wire logic MCLK,
    input wire logic RST,
    output ptf_pkg::ptf_time_t SRC_VAL_1,
    output ptf_pkg::ptf_time_t SRC_VAL_2,
    output ptf_pkg::ptf_time_t SRC_VAL_3,
    output ptf_pkg::ptf_time_t SRC_VAL_4
);
    import ptf_pkg::*;

    // Each neighbour shows zero in reset and its settled value after it.
    always_ff @(posedge MCLK) begin
        SRC_VAL_1 <= RST ? 16'h0000 : V1;
        SRC_VAL_2 <= RST ? 16'h0000 : V2;
        SRC_VAL_3 <= RST ? 16'h0000 : V3;
        SRC_VAL_4 <= RST ? 16'h0000 : V4;
    end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the relay, the two pulse generators and the random delay.
// Assumes ptf_pkg is compiled first; the tick is shortened to TC clocks.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ptf_pkg::*;

    localparam int TC = 4;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic restart = 1'b0;
    logic etr_trg = 1'b0;
    logic etr_rst = 1'b0;
    logic etr_legacy = 1'b0;
    logic etr_retain = 1'b0;
    logic sym_en = 1'b0;
    logic asy_en = 1'b0;
    logic asy_flip = 1'b0;
    logic rnd_en = 1'b0;
    logic [3:0] etr_repeat = 4'h1;
    ptf_time_t etr_hi = 16'h0003;
    ptf_time_t etr_lo = 16'h0002;
    ptf_time_t sym_half = 16'h000a;
    ptf_time_t asy_hi = 16'h0002;
    ptf_time_t asy_lo = 16'h0003;
    ptf_time_t rnd_hi = 16'h0014;
    ptf_time_t rnd_lo = 16'h0014;
    logic [2:0] etr_hsel = 3'h0;
    logic [2:0] etr_lsel = 3'h0;
    logic [2:0] sym_sel = 3'h5;
    logic [2:0] asy_hsel = 3'h0;
    logic [2:0] asy_lsel = 3'h0;
    logic [2:0] rnd_hsel = 3'h0;
    logic [2:0] rnd_lsel = 3'h0;
    ptf_time_t src1, src2, src3, src4, etr_el;
    logic etr_q, sym_q, asy_q, rnd_q;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;

    ptf_src_model i_ptf_src_model (.MCLK(mclk), .RST(rst), .SRC_VAL_1(src1), .SRC_VAL_2(src2),
        .SRC_VAL_3(src3), .SRC_VAL_4(src4));

    ptf_timers #(.TICK_CYCLES(TC)) i_ptf_timers (.MCLK(mclk), .RST(rst), .RESTART(restart),
        .SRC_VAL_1(src1), .SRC_VAL_2(src2), .SRC_VAL_3(src3), .SRC_VAL_4(src4),
        .ETR_TRG(etr_trg), .ETR_RST(etr_rst), .ETR_LEGACY(etr_legacy), .ETR_RETAIN(etr_retain),
        .ETR_REPEAT(etr_repeat), .ETR_HIGH_TIME(etr_hi), .ETR_LOW_TIME(etr_lo),
        .ETR_HIGH_SEL(etr_hsel), .ETR_LOW_SEL(etr_lsel), .SYM_EN(sym_en),
        .SYM_HALF_PERIOD(sym_half), .SYM_HALF_SEL(sym_sel), .ASY_EN(asy_en),
        .ASY_POLARITY_FLIP(asy_flip), .ASY_HIGH_TIME(asy_hi), .ASY_LOW_TIME(asy_lo),
        .ASY_HIGH_SEL(asy_hsel), .ASY_LOW_SEL(asy_lsel), .RND_EN(rnd_en),
        .RND_HIGH_TIME(rnd_hi), .RND_LOW_TIME(rnd_lo), .RND_HIGH_SEL(rnd_hsel),
        .RND_LOW_SEL(rnd_lsel), .ETR_Q(etr_q), .ETR_ELAPSED(etr_el), .SYM_Q(sym_q),
        .ASY_Q(asy_q), .RND_Q(rnd_q));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 mclk = ~mclk;

    // A hang is cut short once the cycle count passes the ceiling.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            results();
        end
    end

    // Counts a comparison and reports a mismatch at once.
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
        end
    endtask

    // Picks one of the four timer outputs by number.
    function automatic logic q_of(int k);
        case (k)
            0: q_of = etr_q;
            1: q_of = sym_q;
            2: q_of = asy_q;
            default: q_of = rnd_q;
        endcase
    endfunction

    // Waits at falling edges until an output reaches a level, at most lim cycles.
    task automatic wait_for(int k, logic v, int lim, output int n);
        n = 0;
        while (q_of(k) !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask

    // Counts how many cycles an output keeps its present level, at most lim.
    task automatic span(int k, int lim, output int n);
        logic v;
        v = q_of(k);
        n = 0;
        while (q_of(k) === v && n < lim) begin
            @(negedge mclk);
            n++;
        end
    endtask

    // Triggers the relay and measures the pause, every pulse and the silence after.
    task automatic t_relay(logic [3:0] rep, int nrep, int lo, int hi);
        int n;
        @(posedge mclk);
        etr_repeat <= rep;
        etr_trg <= 1'b1;
        @(negedge mclk);
        wait_for(0, 1'b1, (lo + 1) * TC + 4, n);
        check("relay pause", n >= (lo - 1) * TC && n <= lo * TC + 3, 1'b1);
        for (int i = 0; i < nrep; i++) begin
            span(0, 5000, n);
            check("relay pulse", n, hi * TC);
            span(0, (i < nrep - 1) ? 5000 : 2 * (lo + hi) * TC, n);
            check("relay gap", n, (i < nrep - 1) ? lo * TC : 2 * (lo + hi) * TC);
        end
        @(posedge mclk);
        etr_trg <= 1'b0;
    endtask

    // Pulses one control of the relay (none when which is 3) during its pulse and checks the output after.
    task automatic t_relay_ctl(int which, logic exp_q);
        int n;
        @(posedge mclk);
        etr_trg <= 1'b1;
        // The second falling edge is the first one at which the new trigger has acted.
        repeat (2) @(negedge mclk);
        wait_for(0, 1'b1, 40, n);
        @(posedge mclk);
        etr_trg <= (which == 0) ? 1'b0 : 1'b1;
        etr_rst <= (which == 1);
        restart <= (which == 2);
        @(posedge mclk);
        etr_trg <= 1'b1;
        etr_rst <= 1'b0;
        restart <= 1'b0;
        @(negedge mclk);
        wait_for(0, exp_q, 3, n);
        check("relay output", etr_q, exp_q);
        if (!exp_q) check("relay elapsed", etr_el, 32'h0);
        if (which == 0) begin
            wait_for(0, 1'b1, 4 * TC, n);
            span(0, 5000, n);
            check("restarted pulse", n, 3 * TC);
        end
        @(posedge mclk);
        etr_trg <= 1'b0;
        repeat (8 * TC) @(posedge mclk);
    endtask

    // Measures a free-running generator after skipping the high level that is running.
    // That level may have begun between ticks, so only later levels have exact lengths.
    task automatic t_gen(int k, int first, int second);
        int n;
        repeat (2) @(negedge mclk);
        wait_for(k, 1'b1, 100, n);
        span(k, 5000, n);
        span(k, 5000, n);
        check("generator second level", n, second * TC);
        span(k, 5000, n);
        check("generator first level", n, first * TC);
        @(posedge mclk);
    endtask

    // Changes the random enable and checks how the output follows it.
    task automatic t_rnd(logic en, int lim, logic exp_q, int bounce);
        int n;
        @(posedge mclk);
        rnd_en <= en;
        if (bounce > 0) begin
            repeat (bounce) @(posedge mclk);
            rnd_en <= ~en;
        end
        @(negedge mclk);
        // A cancelled delay must never move the output; a kept one must move it in time.
        wait_for(3, (bounce > 0) ? ~exp_q : exp_q, lim, n);
        check("random output", rnd_q, exp_q);
        @(posedge mclk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence: reset, then every timer in turn.
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check("outputs after reset", {etr_q, sym_q, asy_q, rnd_q, etr_el}, 32'h0);
        t_relay(4'h1, 1, 2, 3);
        t_relay(4'h9, 9, 2, 3);
        t_relay(4'h0, 1, 2, 3);
        t_relay(4'hc, 9, 2, 3);
        t_relay_ctl(0, 1'b0);
        t_relay_ctl(1, 1'b0);
        etr_retain <= 1'b1;
        t_relay_ctl(2, 1'b1);
        etr_retain <= 1'b0;
        t_relay_ctl(2, 1'b0);
        etr_hsel <= 3'h2;
        etr_lsel <= 3'h1;
        t_relay(4'h1, 1, 2, 5);
        etr_legacy <= 1'b1;
        t_relay_ctl(1, 1'b1);
        etr_legacy <= 1'b0;
        sym_en <= 1'b1;
        t_gen(1, 10, 10);
        sym_en <= 1'b0;
        asy_en <= 1'b1;
        t_gen(2, 2, 3);
        asy_flip <= 1'b1;
        t_gen(2, 3, 2);
        asy_en <= 1'b0;
        repeat (3) @(posedge mclk);
        t_relay_ctl(3, 1'b1);
        check("disabled generators", {sym_q, asy_q}, 32'h0);
        asy_flip <= 1'b0;
        asy_hsel <= 3'h3;
        asy_lsel <= 3'h4;
        asy_en <= 1'b1;
        t_gen(2, 1, 3);
        asy_en <= 1'b0;
        t_rnd(1'b1, 20 * TC + 4, 1'b1, 0);
        t_rnd(1'b0, 20 * TC + 4, 1'b0, 0);
        rnd_hi <= 16'h03e8;
        t_rnd(1'b1, 100, 1'b0, 2);
        rnd_hi <= 16'h0000;
        t_rnd(1'b1, 4, 1'b1, 0);
        rnd_lo <= 16'h03e8;
        t_rnd(1'b0, 100, 1'b1, 2);
        results();
    end
endmodule
